// *** bench/usb_core_model.sv ***
/* USB core side model: turns a request into one-cycle reset pulses.
   Assumes requests last one cycle on i_clk_sys. */
`timescale 1ns/100ps
module usb_core_model (
	input  wire i_clk_sys,
	input  wire i_req,
	input  wire i_lite,
	output reg  o_usb_reset,
	output reg  o_lite_reset
);
	initial begin
		o_usb_reset = 1'b0;
		o_lite_reset = 1'b0;
	end
	// Registered so the pulse never shares an edge with the request
	always @(posedge i_clk_sys) begin
		o_usb_reset <= i_req & ~i_lite;
		o_lite_reset <= i_req & i_lite;
	end
endmodule

// *** bench/usb_link_power_timeout_config_props.sv ***
/* Port checker for the link power config bank.
   Assumes one clock and a synchronous active high reset. */
`timescale 1ns/100ps
module lpc_checker (
	input wire        i_clk_sys,
	input wire        i_reset,
	input wire        i_psel,
	input wire        i_penable,
	input wire        i_fs_mode,
	input wire        i_host_u1_feature,
	input wire [31:0] o_prdata,
	input wire        o_pready,
	input wire        o_pslverr,
	input wire        o_u1_self_initiate,
	input wire        o_u1_host_accept,
	input wire        o_latency_msg_on,
	input wire [2:0]  o_gap_calibration,
	input wire [12:0] o_gap_timeout_tenths
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);
	// Gap figures lag speed by one edge, so skip the edge after reset
	property p_self; o_u1_self_initiate |-> $past(i_host_u1_feature); endproperty
	property p_fs_gap; $past(i_fs_mode) && !$past(i_reset) |->
		o_gap_timeout_tenths == 13'h00A0 + 13'h0002 * o_gap_calibration; endproperty
	property p_fs_win; $past(i_fs_mode) && !$past(i_reset) |->
		o_gap_timeout_tenths >= 13'h00A0 && o_gap_timeout_tenths <= 13'h00B4; endproperty
	property p_hs_gap; !$past(i_fs_mode) && !$past(i_reset) |->
		o_gap_timeout_tenths == 13'h1CC0 + 13'h0050 * o_gap_calibration; endproperty
	property p_rsvd; o_pready |-> (o_prdata & 32'hFFFF_188F) == 32'h0000_0000; endproperty
	property p_dflt; $past(i_reset, 2) && !$past(i_reset) |-> o_u1_host_accept
		&& !o_u1_self_initiate && !o_latency_msg_on && !o_pready; endproperty
	property p_pulse; o_pready |-> $past(i_psel && i_penable) ##1 !o_pready; endproperty
	property p_err; o_pslverr |-> o_pready && o_prdata == 32'h0000_0000; endproperty
	a_self: assert property (p_self) else $error("self U1 without host feature");
	a_fs_gap: assert property (p_fs_gap) else $error("fs timeout wrong");
	a_fs_win: assert property (p_fs_win) else $error("fs timeout outside window");
	a_hs_gap: assert property (p_hs_gap) else $error("hs timeout wrong");
	a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
	a_dflt: assert property (p_dflt) else $error("reset defaults wrong");
	a_pulse: assert property (p_pulse) else $error("pready not one cycle");
	a_err: assert property (p_err) else $error("error without zero data");
	c_err: cover property (o_pslverr);
	c_self: cover property (o_u1_self_initiate);
	c_hs: cover property (!i_fs_mode ##1 o_gap_calibration != 3'h0);
endmodule
bind usb_link_power_timeout_config lpc_checker chk (.i_clk_sys(i_clk_sys),
	.i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable), .i_fs_mode(i_fs_mode),
	.i_host_u1_feature(i_host_u1_feature), .o_prdata(o_prdata), .o_pready(o_pready),
	.o_pslverr(o_pslverr), .o_u1_self_initiate(o_u1_self_initiate),
	.o_u1_host_accept(o_u1_host_accept), .o_latency_msg_on(o_latency_msg_on),
	.o_gap_calibration(o_gap_calibration), .o_gap_timeout_tenths(o_gap_timeout_tenths));

// *** bench/usb_link_power_timeout_config_test.sv ***
/* Testbench for the link power config bank over APB.
   Assumes one wait state or more; waits are bounded. */
`timescale 1ns/100ps
module usb_link_power_timeout_config_test;
	localparam [11:0] A = 12'h084;
	reg clk = 1'b0, i_reset = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h0000_0000;
	reg fs = 1'b1, feat = 1'b0, guard = 1'b0, req = 1'b0, lite = 1'b0, ld = 1'b0;
	reg [3:0] strb = 4'hF;
	wire [31:0] prdata;
	wire pready, perr, usb_rst, lite_rst, self_o, acc_o, ltm_o;
	wire [2:0] cal;
	wire [12:0] tout;
	reg [31:0] r;
	reg e;
	int n_fail = 0, comparisons = 0, cyc = 0;
	always #50 clk = ~clk;
	usb_core_model core (.i_clk_sys(clk), .i_req(req), .i_lite(lite),
		.o_usb_reset(usb_rst), .o_lite_reset(lite_rst));
	usb_link_power_timeout_config dut (.i_clk_sys(clk), .i_reset(i_reset),
		.i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
		.i_pwdata(pwdata), .i_pstrb(strb), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(perr), .i_usb_reset(usb_rst), .i_lite_reset(lite_rst),
		.i_rst_protect(guard), .i_fs_mode(fs), .i_host_u1_feature(feat),
		.i_image_load(ld), .i_image_u1_self(1'b1), .i_image_u1_accept(1'b0),
		.i_image_ltm(1'b1), .i_image_fs_cal(3'h5), .i_image_hs_cal(3'h3),
		.o_u1_self_initiate(self_o), .o_u1_host_accept(acc_o),
		.o_latency_msg_on(ltm_o), .o_gap_calibration(cal),
		.o_gap_timeout_tenths(tout));
	task print_verdict;
		$display("fails %0d comparisons %0d", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		comparisons++;
		if (g !== x) begin
			n_fail++;
			$display("mismatch %s exp %h got %h", nm, x, g);
		end
	endtask
	// Request held until pready is seen high at a rising edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task rd(input logic [31:0] x);
		apb(1'b0, A, 32'h0000_0000);
		chk("cfg", x, r);
	endtask
	task rst(input logic l);
		@(posedge clk);
		req <= 1'b1;
		lite <= l;
		@(posedge clk);
		req <= 1'b0;
		@(posedge clk);
	endtask
	task settle;
		repeat (3) @(posedge clk);
	endtask
	// Hang guard counts as a mismatch
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_fail++;
			print_verdict;
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		i_reset <= 1'b0;
		rd(32'h0000_0200);
		chk("acc", 32'h1, acc_o);
		$display("test defaults done");
		apb(1'b1, A, 32'hFFFF_FFFF);
		settle;
		rd(32'h0000_E770);
		chk("ltm", 32'h1, ltm_o);
		chk("self", 32'h0, self_o);
		chk("cal", 32'h7, cal);
		chk("tout", 32'h0000_00AE, tout);
		feat <= 1'b1;
		fs <= 1'b0;
		settle;
		chk("self", 32'h1, self_o);
		chk("tout", 32'h0000_1EF0, tout);
		$display("test fields done");
		apb(1'b1, A, 32'h0000_0400);
		settle;
		chk("self", 32'h1, self_o);
		chk("acc", 32'h0, acc_o);
		apb(1'b1, A, 32'h0000_0200);
		settle;
		chk("self", 32'h0, self_o);
		chk("acc", 32'h1, acc_o);
		chk("ltm", 32'h0, ltm_o);
		strb <= 4'h1;
		apb(1'b1, A, 32'h0000_FFFF);
		strb <= 4'hF;
		rd(32'h0000_0270);
		$display("test independence done");
		apb(1'b1, 12'h088, 32'hFFFF_FFFF);
		chk("err", 32'h1, e);
		apb(1'b0, 12'h088, 32'h0000_0000);
		chk("err", 32'h1, e);
		chk("data", 32'h0, r);
		rd(32'h0000_0270);
		$display("test unmapped done");
		apb(1'b1, A, 32'h0000_E770);
		guard <= 1'b1;
		rst(1'b0);
		rd(32'h0000_0700);
		guard <= 1'b0;
		rst(1'b1);
		rd(32'h0000_0200);
		@(posedge clk);
		ld <= 1'b1;
		@(posedge clk);
		ld <= 1'b0;
		rd(32'h0000_6550);
		apb(1'b1, A, 32'h0000_0000);
		rst(1'b1);
		rd(32'h0000_6550);
		$display("test resets done");
		print_verdict;
	end
endmodule

// *** design/gap_timeout_calc.v ***
/*
 Inter-packet gap timeout calculator: picks the calibration field for
 the current link speed and turns it into the effective timeout.
 Assumes the speed flag and calibration fields are on i_clk_sys.
*/
`timescale 1ns/100ps
`include "usb_link_power_timeout_config_map.vh"

module gap_timeout_calc (
	input  wire        i_clk_sys,
	input  wire        i_reset,
	input  wire        i_fs_mode,
	input  wire [2:0]  i_fs_cal,
	input  wire [2:0]  i_hs_cal,
	output reg  [2:0]  o_cal_q,
	output reg  [12:0] o_timeout_q
);

	// Keeps a result inside the window the USB standard allows
	function [12:0] clamp;
		input [12:0] val;
		input [12:0] lo;
		input [12:0] hi;
		begin
			if (val < lo)
				clamp = lo;
			else if (val > hi)
				clamp = hi;
			else
				clamp = val;
		end
	endfunction

	wire [12:0] fs_add;
	wire [12:0] hs_add;
	wire [12:0] fs_sum;
	wire [12:0] hs_sum;

	// Each PHY clock adds 0.2 bit times at full speed, 8 at high speed
	assign fs_add = {10'h000, i_fs_cal} * `LPC_FS_STEP_TENTHS;
	assign hs_add = {10'h000, i_hs_cal} * `LPC_HS_STEP_TENTHS;
	assign fs_sum = `LPC_FS_BASE_TENTHS + fs_add;
	assign hs_sum = `LPC_HS_BASE_TENTHS + hs_add;

	// Registered so the core sees a glitch-free value on speed changes
	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_cal_q     <= 3'h0;
			o_timeout_q <= `LPC_FS_BASE_TENTHS;
		end else if (i_fs_mode) begin
			o_cal_q     <= i_fs_cal;
			o_timeout_q <= clamp(fs_sum, `LPC_FS_MIN_TENTHS, `LPC_FS_MAX_TENTHS);
		end else begin
			o_cal_q     <= i_hs_cal;
			o_timeout_q <= clamp(hs_sum, `LPC_HS_MIN_TENTHS, `LPC_HS_MAX_TENTHS);
		end
	end

endmodule

// *** design/usb_link_power_timeout_config.v ***
/*
 APB register bank for U1 link power enables, latency tolerance
 messaging enable and the inter-packet gap calibration fields.
 Only byte address 12'h084 is mapped; any other address gets an
 error answer. Each access takes one wait state. The chip reset
 loads the no-image defaults; usb and lite resets load the last
 stored image, or only its calibration fields while i_rst_protect is set.
 Assumes APB master, USB core strobes and image loader all run on
 i_clk_sys; usb and lite reset requests are one-cycle pulses.
*/
// How it works
// - Self-initiated U1 needs bit and host feature
// - Host U1 requests accepted when bit set
// - Both U1 bits act fully independently
// - Guarded resets keep U1 and latency bits
// - Latency messaging follows its enable bit
// - Full-speed calibration times factor added to timeout
// - Full-speed timeout held within 16-18 bit times
// - Each full-speed PHY clock adds 0.2 bits
// - Only 60 MHz factors are implemented
// - Not full speed: present high-speed calibration
// - Each high-speed PHY clock adds 8 bits
// - Self-initiate and latency default 0, restore image
// - Host-accept defaults 1, restores to image
`timescale 1ns/100ps
`include "usb_link_power_timeout_config_map.vh"

module usb_link_power_timeout_config (
	input  wire        i_clk_sys,
	input  wire        i_reset,
	// APB slave
	input  wire        i_psel,
	input  wire        i_penable,
	input  wire        i_pwrite,
	input  wire [11:0] i_paddr,
	input  wire [31:0] i_pwdata,
	input  wire [3:0]  i_pstrb,
	output reg  [31:0] o_prdata,
	output reg         o_pready,
	output reg         o_pslverr,
	// USB core status and reset requests
	input  wire        i_usb_reset,
	input  wire        i_lite_reset,
	input  wire        i_rst_protect,
	input  wire        i_fs_mode,
	input  wire        i_host_u1_feature,
	// Configuration image loader
	input  wire        i_image_load,
	input  wire        i_image_u1_self,
	input  wire        i_image_u1_accept,
	input  wire        i_image_ltm,
	input  wire [2:0]  i_image_fs_cal,
	input  wire [2:0]  i_image_hs_cal,
	// Controls toward the USB device core
	output reg         o_u1_self_initiate,
	output reg         o_u1_host_accept,
	output reg         o_latency_msg_on,
	output wire [2:0]  o_gap_calibration,
	output wire [12:0] o_gap_timeout_tenths
);

	// Merges one write byte lane into the old byte under its strobe.
	// Lanes 2 and 3 carry no fields, so their strobes are not looked at.
	function [7:0] lane_merge;
		input [7:0] old_val;
		input [7:0] new_val;
		input       strobe;
		begin
			if (strobe)
				lane_merge = new_val;
			else
				lane_merge = old_val;
		end
	endfunction

	// Software visible fields
	reg        u1_self_initiate_allow_q;
	reg        u1_host_request_accept_q;
	reg        latency_tolerance_msg_on_q;
	reg  [2:0] fullspeed_gap_calibration_q;
	reg  [2:0] highspeed_gap_calibration_q;

	// Last loaded configuration image
	reg        img_u1_self_q;
	reg        img_u1_accept_q;
	reg        img_ltm_q;
	reg  [2:0] img_fs_cal_q;
	reg  [2:0] img_hs_cal_q;

	// Next values of the software visible fields
	reg        u1_self_initiate_allow_d;
	reg        u1_host_request_accept_d;
	reg        latency_tolerance_msg_on_d;
	reg  [2:0] fullspeed_gap_calibration_d;
	reg  [2:0] highspeed_gap_calibration_d;

	// Next values of the image store
	reg        img_u1_self_d;
	reg        img_u1_accept_d;
	reg        img_ltm_d;
	reg  [2:0] img_fs_cal_d;
	reg  [2:0] img_hs_cal_d;

	// Next values of the bus answer
	reg        pready_d;
	reg        pslverr_d;
	reg [31:0] prdata_d;

	// Next values of the controls toward the core
	reg        u1_self_initiate_d;
	reg        u1_host_accept_d;
	reg        latency_msg_on_d;

	// Bus decode
	wire        addr_hit;
	wire        access;
	wire        wr_commit;
	wire        usb_side_reset;
	wire [31:0] cfg_word;
	wire [7:0]  wr_lane0;
	wire [7:0]  wr_lane1;
	wire        wr_u1_self;
	wire        wr_u1_accept;
	wire        wr_ltm;
	wire [2:0]  wr_fs_cal;
	wire [2:0]  wr_hs_cal;

	assign addr_hit       = (i_paddr == `LPC_ADDR_CONFIG);
	assign access         = i_psel & i_penable;
	// Writes land only at the edge where the master sees pready high
	assign wr_commit      = access & o_pready & i_pwrite & addr_hit;
	// A usb reset and a lite reset act the same on this bank
	assign usb_side_reset = i_usb_reset | i_lite_reset;

	// Current register image; unlisted and reserved bits read as zero
	assign cfg_word = {16'h0000,
		highspeed_gap_calibration_q,
		2'h0,
		u1_self_initiate_allow_q,
		u1_host_request_accept_q,
		latency_tolerance_msg_on_q,
		1'h0,
		fullspeed_gap_calibration_q,
		4'h0};

	assign wr_lane0 = lane_merge(cfg_word[7:0], i_pwdata[7:0], i_pstrb[0]);
	assign wr_lane1 = lane_merge(cfg_word[15:8], i_pwdata[15:8], i_pstrb[1]);

	// Field values of a write, each lane already merged under its strobe
	assign wr_u1_self   = wr_lane1[`LPC_BIT_U1_SELF - 8];
	assign wr_u1_accept = wr_lane1[`LPC_BIT_U1_ACCEPT - 8];
	assign wr_ltm       = wr_lane1[`LPC_BIT_LTM - 8];
	assign wr_fs_cal    = wr_lane0[`LPC_FS_CAL_MSB:`LPC_FS_CAL_LSB];
	assign wr_hs_cal    = wr_lane1[`LPC_HS_CAL_MSB - 8:`LPC_HS_CAL_LSB - 8];

	// APB answer: one wait state, then pready for a single cycle.
	// Registering the answer keeps every bus output on a flip-flop; the
	// price is a fixed wait state on every access.
	always @* begin
		pready_d  = 1'b0;
		pslverr_d = 1'b0;
		prdata_d  = 32'h0000_0000;
		if (access & ~o_pready) begin
			// Unmapped addresses answer with an error and zero data
			pready_d  = 1'b1;
			pslverr_d = ~addr_hit;
			if (~i_pwrite & addr_hit)
				prdata_d = cfg_word;
		end
	end

	// Bus answer registers
	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_pready  <= 1'b0;
			o_prdata  <= 32'h0000_0000;
			o_pslverr <= 1'b0;
		end else begin
			o_pready  <= pready_d;
			o_prdata  <= prdata_d;
			o_pslverr <= pslverr_d;
		end
	end

	// Image store: defaults until a loader supplies a real image.
	// Usb and lite resets read from it and never change it.
	always @* begin
		img_u1_self_d   = img_u1_self_q;
		img_u1_accept_d = img_u1_accept_q;
		img_ltm_d       = img_ltm_q;
		img_fs_cal_d    = img_fs_cal_q;
		img_hs_cal_d    = img_hs_cal_q;
		if (i_image_load) begin
			img_u1_self_d   = i_image_u1_self;
			img_u1_accept_d = i_image_u1_accept;
			img_ltm_d       = i_image_ltm;
			img_fs_cal_d    = i_image_fs_cal;
			img_hs_cal_d    = i_image_hs_cal;
		end
	end

	// Image registers; after a chip reset no stored image exists
	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			img_u1_self_q   <= `LPC_RST_U1_SELF;
			img_u1_accept_q <= `LPC_RST_U1_ACCEPT;
			img_ltm_q       <= `LPC_RST_LTM;
			img_fs_cal_q    <= `LPC_RST_FS_CAL;
			img_hs_cal_q    <= `LPC_RST_HS_CAL;
		end else begin
			img_u1_self_q   <= img_u1_self_d;
			img_u1_accept_q <= img_u1_accept_d;
			img_ltm_q       <= img_ltm_d;
			img_fs_cal_q    <= img_fs_cal_d;
			img_hs_cal_q    <= img_hs_cal_d;
		end
	end

	// Next field values. Priority, highest first: image load, usb or
	// lite reset, APB write. A reset request beats a software write in
	// the same cycle so the core never starts from a half-written state.
	always @* begin
		u1_self_initiate_allow_d    = u1_self_initiate_allow_q;
		u1_host_request_accept_d    = u1_host_request_accept_q;
		latency_tolerance_msg_on_d  = latency_tolerance_msg_on_q;
		fullspeed_gap_calibration_d = fullspeed_gap_calibration_q;
		highspeed_gap_calibration_d = highspeed_gap_calibration_q;
		// A fresh image replaces the stored copy and the live fields
		if (i_image_load) begin
			u1_self_initiate_allow_d    = i_image_u1_self;
			u1_host_request_accept_d    = i_image_u1_accept;
			latency_tolerance_msg_on_d  = i_image_ltm;
			fullspeed_gap_calibration_d = i_image_fs_cal;
			highspeed_gap_calibration_d = i_image_hs_cal;
		end else if (usb_side_reset) begin
			// Calibration fields are not guarded: every such reset reloads
			fullspeed_gap_calibration_d = img_fs_cal_q;
			highspeed_gap_calibration_d = img_hs_cal_q;
			// With the guard set the link power bits keep their values
			if (~i_rst_protect) begin
				u1_self_initiate_allow_d   = img_u1_self_q;
				u1_host_request_accept_d   = img_u1_accept_q;
				latency_tolerance_msg_on_d = img_ltm_q;
			end
		end else if (wr_commit) begin
			// An APB write changes only what its byte strobes select
			u1_self_initiate_allow_d    = wr_u1_self;
			u1_host_request_accept_d    = wr_u1_accept;
			latency_tolerance_msg_on_d  = wr_ltm;
			fullspeed_gap_calibration_d = wr_fs_cal;
			highspeed_gap_calibration_d = wr_hs_cal;
		end
	end

	// Field registers; a chip reset loads the no-image defaults
	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			u1_self_initiate_allow_q    <= `LPC_RST_U1_SELF;
			u1_host_request_accept_q    <= `LPC_RST_U1_ACCEPT;
			latency_tolerance_msg_on_q  <= `LPC_RST_LTM;
			fullspeed_gap_calibration_q <= `LPC_RST_FS_CAL;
			highspeed_gap_calibration_q <= `LPC_RST_HS_CAL;
		end else begin
			u1_self_initiate_allow_q    <= u1_self_initiate_allow_d;
			u1_host_request_accept_q    <= u1_host_request_accept_d;
			latency_tolerance_msg_on_q  <= latency_tolerance_msg_on_d;
			fullspeed_gap_calibration_q <= fullspeed_gap_calibration_d;
			highspeed_gap_calibration_q <= highspeed_gap_calibration_d;
		end
	end

	// Controls toward the core. Each U1 output looks at its own bit
	// only, so one enable can never mask the other. The self-initiate
	// path also needs the host's U1 feature.
	always @* begin
		u1_self_initiate_d = u1_self_initiate_allow_q & i_host_u1_feature;
		u1_host_accept_d   = u1_host_request_accept_q;
		latency_msg_on_d   = latency_tolerance_msg_on_q;
	end

	// Control registers; they read 0 while the chip reset is held
	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_u1_self_initiate <= 1'b0;
			o_u1_host_accept   <= 1'b0;
			o_latency_msg_on   <= 1'b0;
		end else begin
			o_u1_self_initiate <= u1_self_initiate_d;
			o_u1_host_accept   <= u1_host_accept_d;
			o_latency_msg_on   <= latency_msg_on_d;
		end
	end

	// Speed dependent gap calibration and effective timeout; both are
	// registered in the submodule, so they lag i_fs_mode by one edge
	gap_timeout_calc u_gap (
		.i_clk_sys   (i_clk_sys),
		.i_reset     (i_reset),
		.i_fs_mode   (i_fs_mode),
		.i_fs_cal    (fullspeed_gap_calibration_q),
		.i_hs_cal    (highspeed_gap_calibration_q),
		.o_cal_q     (o_gap_calibration),
		.o_timeout_q (o_gap_timeout_tenths)
	);

endmodule

// *** design/usb_link_power_timeout_config_map.vh ***
/*
 Register map, field positions, reset values and gap timing figures
 for the USB link power and inter-packet timeout configuration bank.
 Assumes it is included by its bare name from the design files.
*/
`ifndef USB_LINK_POWER_TIMEOUT_CONFIG_MAP_VH
`define USB_LINK_POWER_TIMEOUT_CONFIG_MAP_VH

// APB byte address of the configuration word
`define LPC_ADDR_CONFIG      12'h084

// Field positions inside the configuration word
`define LPC_BIT_U1_SELF      10
`define LPC_BIT_U1_ACCEPT    9
`define LPC_BIT_LTM          8
`define LPC_FS_CAL_LSB       4
`define LPC_FS_CAL_MSB       6
`define LPC_HS_CAL_LSB       13
`define LPC_HS_CAL_MSB       15

// Values used when no stored configuration image exists
`define LPC_RST_U1_SELF      1'h0
`define LPC_RST_U1_ACCEPT    1'h1
`define LPC_RST_LTM          1'h0
`define LPC_RST_FS_CAL       3'h0
`define LPC_RST_HS_CAL       3'h0

// Gap timing in tenths of a bit time, 60 MHz PHY clock only
`define LPC_FS_BASE_TENTHS   13'h00A0
`define LPC_FS_MIN_TENTHS    13'h00A0
`define LPC_FS_MAX_TENTHS    13'h00B4
`define LPC_FS_STEP_TENTHS   13'h0002
`define LPC_HS_BASE_TENTHS   13'h1CC0
`define LPC_HS_MIN_TENTHS    13'h1CC0
`define LPC_HS_MAX_TENTHS    13'h1FE0
`define LPC_HS_STEP_TENTHS   13'h0050

`endif
